// ==== hw/tpw_tag.sv ====
// Tag end: write, compatibility write, multi-page read and counter read handling.

// Contract
// - active state multi-read at protected page: NAK
// - password and acknowledge pages read as zero
// - reader buffers whole multi-read answer; code passes each byte out on rd_valid as it arrives
// - A2h write stores four bytes to page
// - writes accept pages 02h up to variant limit
// - out of range write: NAK, memory unchanged
// - locked pages never change by any write
// - active state write at protected page: NAK
// - authenticated state ignores password protection
// - lock and OTP pages written tear safe
// - compatibility write stores only bytes 0-3
// - reader zero-fills compatibility bytes 04h-0Fh
// - answer twelve cycles after last command byte, within timeout
// - 39h returns selected 24-bit counter value
// - counter reads ignore password protection
// - reader keeps last page not below first; code sends the pages as given and the tag answers NAK
module tpw_tag
  import tpw_pkg::*;
#(
  parameter int CW_TMO = CW_TMO_CYC
) (
  tpw_link_if.tag link,
  input wire logic variant_large,
  input wire logic authenticated,
  input wire logic [7:0] protected_start_page,
  input wire logic [NUM_PAGES-1:0] page_locked,
  input wire logic [2:0][23:0] counter_value,
  output logic write_done,
  output logic [7:0] write_page
);
  typedef struct packed {
    tpw_tag_st_type st;
    tpw_kind_type kind;
    logic cw;
    logic crc_ok;
    logic [4:0] cnt;
    logic [BUF_BYTES-1:0][7:0] buf_q;
    logic [3:0] gap;
    logic [17:0] tmo;
    logic [3:0] nib;
    logic [7:0] page;
    logic [7:0] end_page;
    logic [1:0] bsel;
    logic [1:0] csel;
    logic [7:0] cw_page;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic rsp_last;
    logic rsp_short;
    logic write_done;
    logic [7:0] write_page;
    logic [NUM_PAGES-1:0][31:0] mem;
  } tpw_tag_state_type;

  tpw_tag_state_type s_reg;
  tpw_tag_state_type s_next;
  logic [7:0] max_page;
  logic [7:0] pwd_page;

  // Variant dependent page limits.
  assign max_page = variant_large ? PAGE_LAST_LARGE : PAGE_LAST_SMALL;
  assign pwd_page = variant_large ? PWD_PAGE_LARGE : PWD_PAGE_SMALL;

  // Checks whether a page may be written in the present state.
  function automatic logic wr_ok(input logic [7:0] pg, input logic [7:0] maxp, input logic auth,
                                 input logic [7:0] psp, input logic [NUM_PAGES-1:0] lk);
    logic ok;
    ok = 1'b0;
    if (pg >= PAGE_FIRST_WR && pg <= maxp) begin
      ok = !lk[pg[5:0]] && (auth || pg < psp);
    end
    return ok;
  endfunction

  // Command collection, decoding, memory update and answer streaming.
  always_comb begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_last = 1'b0;
    s_next.rsp_short = 1'b0;
    s_next.rsp_byte = 8'h00;
    s_next.write_done = 1'b0;
    case (s_reg.st)
      TS_IDLE, TS_CW_DATA: begin
        if (s_reg.st == TS_CW_DATA) begin
          s_next.tmo = s_reg.tmo + 18'h00001;
          if (s_reg.tmo >= 18'(CW_TMO - 1)) begin
            s_next.st = TS_IDLE;
            s_next.cw = 1'b0;
            s_next.cnt = 5'h00;
          end
        end
        if (link.cmd_valid) begin
          if (s_reg.cnt < 5'(BUF_BYTES)) begin
            s_next.buf_q[s_reg.cnt] = link.cmd_byte;
            s_next.cnt = s_reg.cnt + 5'h01;
          end
          if (link.cmd_last) begin
            s_next.st = TS_DECODE;
            s_next.crc_ok = link.cmd_crc_ok;
          end
        end
      end
      TS_DECODE: begin
        s_next.st = TS_GAP;
        s_next.gap = 4'h0;
        s_next.kind = RK_NIBBLE;
        s_next.nib = NIB_NAK;
        s_next.cnt = 5'h00;
        s_next.cw = 1'b0;
        if (!s_reg.crc_ok) begin
          s_next.st = s_reg.cw ? TS_CW_DATA : TS_IDLE;
          s_next.cw = s_reg.cw;
        end else if (s_reg.cw) begin
          if (s_reg.cnt == LEN_CW2) begin
            s_next.mem[s_reg.cw_page[5:0]] = {s_reg.buf_q[3], s_reg.buf_q[2], s_reg.buf_q[1], s_reg.buf_q[0]};
            s_next.write_done = 1'b1;
            s_next.write_page = s_reg.cw_page;
            s_next.nib = NIB_ACK;
          end
        end else if (s_reg.buf_q[0] == CMD_WRITE && s_reg.cnt == LEN_WRITE) begin
          if (wr_ok(s_reg.buf_q[1], max_page, authenticated, protected_start_page, page_locked)) begin
            // whole page committed on one edge
            s_next.mem[s_reg.buf_q[1][5:0]] = {s_reg.buf_q[5], s_reg.buf_q[4], s_reg.buf_q[3], s_reg.buf_q[2]};
            s_next.write_done = 1'b1;
            s_next.write_page = s_reg.buf_q[1];
            s_next.nib = NIB_ACK;
          end
        end else if (s_reg.buf_q[0] == CMD_COMPAT_WRITE && s_reg.cnt == LEN_CW1) begin
          if (wr_ok(s_reg.buf_q[1], max_page, authenticated, protected_start_page, page_locked)) begin
            s_next.cw_page = s_reg.buf_q[1];
            s_next.nib = NIB_ACK;
            s_next.cw = 1'b1; // Marks that the data frame is due next.
          end
        end else if (s_reg.buf_q[0] == CMD_MULTI_READ && s_reg.cnt == LEN_MREAD) begin
          if (s_reg.buf_q[2] <= max_page && s_reg.buf_q[1] <= s_reg.buf_q[2] &&
              (authenticated || s_reg.buf_q[2] < protected_start_page)) begin
            s_next.kind = RK_PAGES;
            s_next.page = s_reg.buf_q[1];
            s_next.end_page = s_reg.buf_q[2];
            s_next.bsel = 2'h0;
          end
        end else if (s_reg.buf_q[0] == CMD_COUNTER_READ && s_reg.cnt == LEN_CREAD) begin
          if (s_reg.buf_q[1] <= CNT_LAST) begin
            s_next.kind = RK_COUNTER;
            s_next.csel = s_reg.buf_q[1][1:0];
            s_next.bsel = 2'h0;
          end
        end
      end
      TS_GAP: begin
        s_next.gap = s_reg.gap + 4'h1;
        if (s_reg.gap >= GAP_CYC - 4'h1) begin
          s_next.st = TS_SEND;
        end
      end
      TS_SEND: begin
        s_next.rsp_valid = 1'b1;
        if (s_reg.kind == RK_NIBBLE) begin
          s_next.rsp_short = 1'b1;
          s_next.rsp_last = 1'b1;
          s_next.rsp_byte = {4'h0, s_reg.nib};
          s_next.st = TS_IDLE;
          // Only an accepted first compatibility frame waits for its data frame.
          if (s_reg.cw) begin
            s_next.st = TS_CW_DATA;
            s_next.tmo = 18'h00000;
          end
        end else if (s_reg.kind == RK_PAGES) begin
          if (s_reg.page == pwd_page || s_reg.page == pwd_page + 8'h01) begin
            s_next.rsp_byte = 8'h00;
          end else begin
            s_next.rsp_byte = s_reg.mem[s_reg.page[5:0]][8*s_reg.bsel +: 8];
          end
          s_next.bsel = s_reg.bsel + 2'h1;
          if (s_reg.bsel == 2'h3) begin
            s_next.page = s_reg.page + 8'h01;
          end
          if (s_reg.bsel == 2'h3 && s_reg.page == s_reg.end_page) begin
            s_next.rsp_last = 1'b1;
            s_next.st = TS_IDLE;
          end
        end else begin
          s_next.rsp_byte = counter_value[s_reg.csel][8*s_reg.bsel +: 8];
          s_next.bsel = s_reg.bsel + 2'h1;
          if (s_reg.bsel == 2'h2) begin
            s_next.rsp_last = 1'b1;
            s_next.st = TS_IDLE;
          end
        end
      end
      default: begin
        s_next.st = TS_IDLE;
      end
    endcase
  end

  // State register; memory clears at reset.
  always_ff @(posedge link.clk or negedge link.arst_n) begin
    if (!link.arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.rsp_valid = s_reg.rsp_valid;
  assign link.rsp_byte = s_reg.rsp_byte;
  assign link.rsp_last = s_reg.rsp_last;
  assign link.rsp_short = s_reg.rsp_short;
  assign write_done = s_reg.write_done;
  assign write_page = s_reg.write_page;
endmodule

// ==== hw/tpw_pkg.sv ====
// Shared constants and types for the tag command link and both of its ends.
package tpw_pkg;
  localparam int CLK_MHZ = 25;
  localparam int T_TIMEOUT_US = 5000;
  localparam int T_CW_DATA_US = 10000;
  localparam int TMO_CYC = T_TIMEOUT_US * CLK_MHZ;
  localparam int CW_TMO_CYC = T_CW_DATA_US * CLK_MHZ;
  localparam logic [3:0] GAP_CYC = 4'h9;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] CMD_COMPAT_WRITE = 8'hA0;
  localparam logic [7:0] CMD_MULTI_READ = 8'h3A;
  localparam logic [7:0] CMD_COUNTER_READ = 8'h39;
  localparam logic [3:0] NIB_ACK = 4'hA;
  localparam logic [3:0] NIB_NAK = 4'h0;
  localparam logic [7:0] PAGE_FIRST_WR = 8'h02;
  localparam logic [7:0] PAGE_LAST_SMALL = 8'h13;
  localparam logic [7:0] PAGE_LAST_LARGE = 8'h28;
  localparam logic [7:0] PWD_PAGE_SMALL = 8'h12;
  localparam logic [7:0] PWD_PAGE_LARGE = 8'h27;
  localparam logic [7:0] LOCK_PAGE = 8'h02;
  localparam logic [7:0] OTP_PAGE = 8'h03;
  localparam logic [7:0] XLOCK_PAGE = 8'h24;
  localparam logic [7:0] CNT_LAST = 8'h02;
  localparam logic [4:0] LEN_WRITE = 5'h06;
  localparam logic [4:0] LEN_CW1 = 5'h02;
  localparam logic [4:0] LEN_CW2 = 5'h10;
  localparam logic [4:0] LEN_MREAD = 5'h03;
  localparam logic [4:0] LEN_CREAD = 5'h02;
  localparam int NUM_PAGES = 41;
  localparam int BUF_BYTES = 18;
  typedef enum logic [2:0] {
    TS_IDLE = 3'b000, TS_DECODE = 3'b001, TS_GAP = 3'b010, TS_SEND = 3'b011, TS_CW_DATA = 3'b100
  } tpw_tag_st_type;
  typedef enum logic [1:0] {
    RK_NIBBLE = 2'b00, RK_PAGES = 2'b01, RK_COUNTER = 2'b10
  } tpw_kind_type;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00, RS_SEND = 2'b01, RS_WAIT = 2'b10
  } tpw_rdr_st_type;
endpackage

// ==== hw/tpw_link_if.sv ====
// Byte-level command link between the reader end and the tag end.
interface tpw_link_if (
  input wire logic clk,
  input wire logic arst_n
);
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_last;
  logic cmd_crc_ok;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_last;
  logic rsp_short;
  modport tag (input clk, arst_n, cmd_valid, cmd_byte, cmd_last, cmd_crc_ok,
    output rsp_valid, rsp_byte, rsp_last, rsp_short);
  modport rdr (input clk, arst_n, rsp_valid, rsp_byte, rsp_last, rsp_short,
    output cmd_valid, cmd_byte, cmd_last, cmd_crc_ok);
endinterface

// ==== hw/tpw_reader.sv ====
// Reader end: frames user requests onto the link and collects the tag answers.
module tpw_reader
  import tpw_pkg::*;
#(
  parameter int TMO = TMO_CYC,
  parameter int CW_TMO = CW_TMO_CYC
) (
  tpw_link_if.rdr link,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic [7:0] req_arg0,
  input wire logic [7:0] req_arg1,
  input wire logic [31:0] req_data,
  output logic busy,
  output logic done,
  output logic done_ack,
  output logic done_nak,
  output logic done_timeout,
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  typedef struct packed {
    tpw_rdr_st_type st;
    logic [BUF_BYTES-1:0][7:0] frame;
    logic [4:0] len;
    logic [4:0] idx;
    logic [17:0] tmo;
    logic [7:0] code;
    logic cw_phase;
    logic [7:0] expect_len;
    logic [7:0] got;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_last;
    logic busy;
    logic done;
    logic done_ack;
    logic done_nak;
    logic done_timeout;
    logic rd_valid;
    logic [7:0] rd_byte;
  } tpw_rdr_state_type;

  tpw_rdr_state_type r_reg;
  tpw_rdr_state_type r_next;

  // Request framing, transmission, answer collection and timeout.
  always_comb begin
    r_next = r_reg;
    r_next.cmd_valid = 1'b0;
    r_next.cmd_last = 1'b0;
    r_next.cmd_byte = 8'h00;
    r_next.done = 1'b0;
    r_next.done_ack = 1'b0;
    r_next.done_nak = 1'b0;
    r_next.done_timeout = 1'b0;
    r_next.rd_valid = 1'b0;
    case (r_reg.st)
      RS_IDLE: begin
        if (req_valid) begin
          r_next.st = RS_SEND;
          r_next.busy = 1'b1;
          r_next.code = req_code;
          r_next.cw_phase = 1'b0;
          r_next.idx = 5'h00;
          r_next.got = 8'h00;
          r_next.frame = '0;
          r_next.frame[0] = req_code;
          r_next.frame[1] = req_arg0;
          r_next.frame[2] = req_arg1;
          r_next.len = LEN_CREAD;
          r_next.expect_len = 8'((req_arg1 - req_arg0 + 8'h01) << 2);
          if (req_code == CMD_WRITE) begin
            r_next.len = LEN_WRITE;
            r_next.frame[5:2] = req_data;
          end else if (req_code == CMD_MULTI_READ) begin
            r_next.len = LEN_MREAD;
          end else if (req_code == CMD_COUNTER_READ) begin
            r_next.expect_len = 8'h03;
          end
        end
      end
      RS_SEND: begin
        r_next.cmd_valid = 1'b1;
        r_next.cmd_byte = r_reg.frame[r_reg.idx];
        r_next.idx = r_reg.idx + 5'h01;
        if (r_reg.idx == r_reg.len - 5'h01) begin
          r_next.cmd_last = 1'b1;
          r_next.st = RS_WAIT;
          r_next.tmo = 18'h00000;
        end
      end
      RS_WAIT: begin
        r_next.tmo = r_reg.tmo + 18'h00001;
        if (link.rsp_valid && link.rsp_short) begin
          if (link.rsp_byte[3:0] == NIB_ACK && r_reg.code == CMD_COMPAT_WRITE && !r_reg.cw_phase) begin
            // data bytes 04h-0Fh sent as zero
            r_next.cw_phase = 1'b1;
            r_next.frame = '0;
            r_next.frame[3:0] = req_data;
            r_next.len = LEN_CW2;
            r_next.idx = 5'h00;
            r_next.st = RS_SEND;
          end else begin
            r_next.done = 1'b1;
            r_next.done_ack = link.rsp_byte[3:0] == NIB_ACK;
            r_next.done_nak = link.rsp_byte[3:0] != NIB_ACK;
            r_next.busy = 1'b0;
            r_next.st = RS_IDLE;
          end
        end else if (link.rsp_valid) begin
          r_next.rd_valid = 1'b1;
          r_next.rd_byte = link.rsp_byte;
          r_next.got = r_reg.got + 8'h01;
          if (link.rsp_last) begin
            r_next.done = 1'b1;
            r_next.done_ack = r_reg.got + 8'h01 == r_reg.expect_len;
            r_next.done_nak = r_reg.got + 8'h01 != r_reg.expect_len;
            r_next.busy = 1'b0;
            r_next.st = RS_IDLE;
          end
        end else if (r_reg.tmo >= (r_reg.cw_phase ? 18'(CW_TMO - 1) : 18'(TMO - 1))) begin
          r_next.done = 1'b1;
          r_next.done_timeout = 1'b1;
          r_next.busy = 1'b0;
          r_next.st = RS_IDLE;
        end
      end
      default: begin
        r_next.st = RS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge link.clk or negedge link.arst_n) begin
    if (!link.arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.cmd_valid = r_reg.cmd_valid;
  assign link.cmd_byte = r_reg.cmd_byte;
  assign link.cmd_last = r_reg.cmd_last;
  assign link.cmd_crc_ok = r_reg.cmd_last;
  assign busy = r_reg.busy;
  assign done = r_reg.done;
  assign done_ack = r_reg.done_ack;
  assign done_nak = r_reg.done_nak;
  assign done_timeout = r_reg.done_timeout;
  assign rd_valid = r_reg.rd_valid;
  assign rd_byte = r_reg.rd_byte;
endmodule

// ==== verif/tpw_link_properties.sv ====
// Concurrent checks on the signals of the tag command link.
module tpw_link_properties
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  input wire logic cmd_crc_ok,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  input wire logic rsp_short
);
  timeunit 1ns;
  timeprecision 1ps;
  logic at_start_reg;
  logic at_start_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Tracks whether the next command byte opens a new frame.
  always_comb begin
    at_start_next = at_start_reg;
    if (cmd_valid) begin
      at_start_next = cmd_last;
    end
  end
  // Registers the frame start marker.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      at_start_reg <= 1'b1;
    end else begin
      at_start_reg <= at_start_next;
    end
  end
  property p_gap;
    cmd_valid && cmd_last && cmd_crc_ok |-> ##1 (!rsp_valid)[*8] ##1 (!rsp_valid)[*3] ##1 rsp_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("answer not on twelfth cycle");
  property p_short;
    rsp_short |-> rsp_valid && rsp_last && rsp_byte[7:4] == 4'h0 &&
      (rsp_byte[3:0] == NIB_ACK || rsp_byte[3:0] == NIB_NAK);
  endproperty
  a_short: assert property (p_short) else $error("bad short answer");
  property p_burst;
    rsp_valid && !rsp_last |=> rsp_valid && !rsp_short;
  endproperty
  a_burst: assert property (p_burst) else $error("answer frame broken");
  property p_end;
    rsp_last |=> !rsp_valid;
  endproperty
  a_end: assert property (p_end) else $error("byte after last answer byte");
  property p_cnt;
    at_start_reg && cmd_valid && cmd_byte == CMD_COUNTER_READ ##1 cmd_valid && cmd_last && cmd_byte <= CNT_LAST
      |-> ##12 rsp_valid && !rsp_short ##1 rsp_valid && !rsp_last ##1 rsp_valid && rsp_last;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter answer not three bytes");
  property p_cnt_bad;
    at_start_reg && cmd_valid && cmd_byte == CMD_COUNTER_READ ##1 cmd_valid && cmd_last && cmd_byte > CNT_LAST
      |-> ##12 rsp_short && rsp_byte[3:0] == NIB_NAK;
  endproperty
  a_cnt_bad: assert property (p_cnt_bad) else $error("bad counter not refused");
  property p_wr_range;
    at_start_reg && cmd_valid && cmd_byte == CMD_WRITE ##1 cmd_valid &&
      (cmd_byte < PAGE_FIRST_WR || cmd_byte > PAGE_LAST_LARGE)
      |-> ##16 rsp_short && rsp_byte[3:0] == NIB_NAK;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write outside pages not refused");
  property p_order;
    at_start_reg && cmd_valid && cmd_byte == CMD_MULTI_READ ##1 cmd_valid ##1
      cmd_valid && cmd_last && cmd_byte < $past(cmd_byte)
      |-> ##12 rsp_short && rsp_byte[3:0] == NIB_NAK;
  endproperty
  a_order: assert property (p_order) else $error("reversed read range not refused");
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench joining the reader end and the tag end.
`define CHK(what, exp, got) begin n_checks++; if ((exp) !== (got)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top
  import tpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, req_valid, busy, done, done_ack, done_nak, done_timeout, rd_valid, write_done;
  logic [7:0] req_code, req_arg0, req_arg1, rd_byte, write_page, protected_start_page, got_page;
  logic [31:0] req_data, r;
  logic [31:0] seed = 32'hFC86FC56;
  logic variant_large, authenticated, got_wd;
  logic [NUM_PAGES-1:0] page_locked;
  logic [2:0][23:0] counter_value;
  logic [31:0] mem [NUM_PAGES];
  logic [7:0] got_q [$];
  logic [2:0] res;
  logic [7:0] corner [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h24, 8'h28, 8'h29};
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  tpw_link_if tpw_link_if_inst (.clk(clk), .arst_n(arst_n));
  tpw_tag #(.CW_TMO(400)) tpw_tag_inst (.link(tpw_link_if_inst), .variant_large(variant_large),
    .authenticated(authenticated), .protected_start_page(protected_start_page), .page_locked(page_locked),
    .counter_value(counter_value), .write_done(write_done), .write_page(write_page));
  tpw_reader #(.TMO(200), .CW_TMO(400)) tpw_reader_inst (.link(tpw_link_if_inst), .req_valid(req_valid),
    .req_code(req_code), .req_arg0(req_arg0), .req_arg1(req_arg1), .req_data(req_data), .busy(busy),
    .done(done), .done_ack(done_ack), .done_nak(done_nak), .done_timeout(done_timeout),
    .rd_valid(rd_valid), .rd_byte(rd_byte));
  tpw_link_properties tpw_link_properties_inst (.clk(clk), .arst_n(arst_n),
    .cmd_valid(tpw_link_if_inst.cmd_valid), .cmd_byte(tpw_link_if_inst.cmd_byte),
    .cmd_last(tpw_link_if_inst.cmd_last), .cmd_crc_ok(tpw_link_if_inst.cmd_crc_ok),
    .rsp_valid(tpw_link_if_inst.rsp_valid), .rsp_byte(tpw_link_if_inst.rsp_byte),
    .rsp_last(tpw_link_if_inst.rsp_last), .rsp_short(tpw_link_if_inst.rsp_short));
  // Free-running clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end
  // Repeatable pseudo-random source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] lim();
    return variant_large ? PAGE_LAST_LARGE : PAGE_LAST_SMALL;
  endfunction
  function automatic logic wr_ok(input logic [7:0] pg);
    return pg >= PAGE_FIRST_WR && pg <= lim() && !page_locked[pg[5:0]] && (authenticated || pg < protected_start_page);
  endfunction
  function automatic logic [7:0] rd_exp(input logic [7:0] pg, input int b);
    logic [7:0] pw;
    pw = variant_large ? PWD_PAGE_LARGE : PWD_PAGE_SMALL;
    if (pg == pw || pg == pw + 8'h01) begin
      return 8'h00;
    end
    return 8'(mem[pg] >> (8 * b));
  endfunction
  // Sets the tag configuration; open means no lock and no protection.
  task automatic cfg(input logic open);
    r = xs();
    variant_large = r[0];
    authenticated = open | r[1];
    protected_start_page = open ? 8'hFF : {2'b00, r[13:8]};
    page_locked = open ? '0 : NUM_PAGES'({xs(), xs()} & {xs(), xs()});
  endtask
  // Issues one request and collects its answer at falling edges.
  task automatic run(input logic [7:0] code, input logic [7:0] a0, input logic [7:0] a1, input logic [31:0] d);
    int n;
    n = 0;
    got_q.delete();
    got_wd = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
    req_code = code;
    req_arg0 = a0;
    req_arg1 = a1;
    req_data = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    do begin
      @(negedge clk);
      if (rd_valid === 1'b1) got_q.push_back(rd_byte);
      if (write_done === 1'b1) begin
        got_wd = 1'b1;
        got_page = write_page;
      end
      n++;
    end while (done !== 1'b1 && n < 2000);
    res = {done_ack, done_nak, done_timeout};
  endtask
  task automatic do_write(input logic [7:0] pg, input logic compat);
    logic [31:0] d;
    logic ok;
    d = xs() | 32'h00000040;
    ok = wr_ok(pg);
    run(compat ? CMD_COMPAT_WRITE : CMD_WRITE, pg, 8'h00, d);
    `CHK("write answer", ok ? 3'b100 : 3'b010, res)
    `CHK("write commit", ok, got_wd)
    if (ok) begin
      `CHK("write page", pg, got_page)
      mem[pg] = d;
    end
  endtask
  task automatic do_read(input logic [7:0] f, input logic [7:0] l);
    logic ok;
    ok = f <= l && l <= lim() && (authenticated || l < protected_start_page);
    run(CMD_MULTI_READ, f, l, 32'h0);
    `CHK("read answer", ok ? 3'b100 : 3'b010, res)
    if (ok) begin
      `CHK("read length", (int'(l) - int'(f) + 1) * 4, got_q.size())
      foreach (got_q[k]) `CHK("read byte", rd_exp(8'(f + k / 4), k % 4), got_q[k])
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset, writes, multi-page reads, counter reads.
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_code = 8'h00;
    req_arg0 = 8'h00;
    req_arg1 = 8'h00;
    req_data = 32'h0;
    counter_value = '0;
    cfg(1'b1);
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 20; i++) begin
      cfg(1'b1);
      variant_large = i[0];
      do_write(corner[i / 2], i[1]);
    end
    for (int i = 0; i < 60; i++) begin
      cfg(1'b0);
      do_write(8'(xs() % 44), seed[3]);
    end
    $display("test writes done");
    cfg(1'b1);
    variant_large = 1'b1;
    do_read(8'h00, PAGE_LAST_LARGE);
    for (int i = 0; i < 30; i++) begin
      cfg(1'b0);
      do_read(8'(xs() % 42), 8'(xs() % 42));
    end
    $display("test reads done");
    for (int i = 0; i < 10; i++) begin
      cfg(1'b0);
      counter_value = 72'({xs(), xs(), xs()});
      run(CMD_COUNTER_READ, 8'(i % 5), 8'h00, 32'h0);
      `CHK("counter answer", (i % 5) <= 2 ? 3'b100 : 3'b010, res)
      if ((i % 5) <= 2) `CHK("counter value", counter_value[i % 5], {got_q[2], got_q[1], got_q[0]})
    end
    $display("test counters done");
    results();
  end
endmodule
